//--- shared/fbd_defines.svh
`ifndef FBD_DEFINES_SVH
`define FBD_DEFINES_SVH

// software port offsets (byte addresses)
`define FBD_ADDR_CTRL     8'h00
`define FBD_ADDR_STATUS   8'h04
`define FBD_ADDR_ACC      8'h08
`define FBD_ADDR_FPTR     8'h0c
`define FBD_ADDR_UJL      8'h10

// control register fields
`define FBD_CTRL_RUN      0
`define FBD_CTRL_PSA      1
`define FBD_CTRL_RESET    2'h0

// status register field positions
`define FBD_ST_CARRY      0
`define FBD_ST_NIBBLE     1
`define FBD_ST_NULL       2
`define FBD_ST_SLEEP      3
`define FBD_ST_TIMEOUT    4

// register file addresses with side effects
`define FBD_PORT_ADDR     7'h05
`define FBD_TIMER_ADDR    7'h01

// reset values
`define FBD_FP_RESET      13'h0000
`define FBD_UJL_RESET     5'h00

// byte-oriented selectors (upper bits 00)
`define FBD_SEL_MISC      4'h0
`define FBD_SEL_CLR       4'h1
`define FBD_SEL_SUB       4'h2
`define FBD_SEL_DEC       4'h3
`define FBD_SEL_IOR       4'h4
`define FBD_SEL_AND       4'h5
`define FBD_SEL_XOR       4'h6
`define FBD_SEL_ADD       4'h7
`define FBD_SEL_MOV       4'h8
`define FBD_SEL_COM       4'h9
`define FBD_SEL_INC       4'ha
`define FBD_SEL_DECSKP    4'hb
`define FBD_SEL_RR        4'hc
`define FBD_SEL_RL        4'hd
`define FBD_SEL_SWAP      4'he
`define FBD_SEL_INCSKP    4'hf

// fixed control words (low byte, upper six bits zero)
`define FBD_W_RETURN      8'h08
`define FBD_W_RETFIE      8'h09
`define FBD_W_STANDBY     8'h63
`define FBD_W_WDTCLR      8'h64

`endif

//--- shared/fbd_pkg.sv
package fbd_pkg;

  // four oscillator periods make one instruction cycle
  typedef enum logic [1:0] {
    FBD_Q1 = 2'b00,
    FBD_Q2 = 2'b01,
    FBD_Q3 = 2'b10,
    FBD_Q4 = 2'b11
  } fbd_phase_t;

  // instruction groups by the two upper bits
  typedef enum logic [1:0] {
    FBD_GRP_BYTE = 2'b00,
    FBD_GRP_BIT  = 2'b01,
    FBD_GRP_CTRL = 2'b10,
    FBD_GRP_LIT  = 2'b11
  } fbd_group_t;

endpackage : fbd_pkg

//--- design/fbd_decoder.sv
`timescale 1ns/1ns
`include "fbd_defines.svh"
// Operation
// - fetch one 14-bit word, split into fields
// - destination bit: 0 accumulator, 1 register
// - bit position selects one bit of byte
// - register index is 7 bits, 0x00-0x7F
// - literal 8 bits data, 11 bits jumps
// - instruction cycle is four clock periods
// - skip or branch adds a nop cycle
// - every register operand is read first
// - port reads return pin levels
// - timer write clears assigned prescaler
// - rotates through carry, only carry changes
// - byte selectors and their flag effects
// - increment/decrement-and-skip on zero, no flags
// - bit operation field layout
// - literal logic ops and move-literal
// - literal add/subtract update three flags
// - returns take two cycles, return-with-literal loads W
// - standby and watchdog-clear update two flags
// - don't-care bits never change decoding
// - jump/call target from latch and immediate
module fbd_decoder #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [13:0] instr_word,
  output logic      [12:0] fetch_pointer,
  output logic             rf_rd_en,
  output logic      [6:0]  rf_rd_addr,
  input  wire logic [7:0]  rf_rd_data,
  output logic             rf_wr_en,
  output logic      [6:0]  rf_wr_addr,
  output logic      [7:0]  rf_wr_data,
  input  wire logic [7:0]  port_pins,
  output logic             prescaler_clr,
  output logic             wdt_clr,
  output logic             sleep_req,
  output logic             gie_set,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata
);

  localparam int SPW = $clog2(STACK_DEPTH);

  fbd_pkg::fbd_phase_t phase_reg;
  logic [13:0] ir_reg;
  logic        ir_valid_reg;
  logic [12:0] fp_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  opnd_reg;
  logic        carry_reg, nibble_carry_reg, result_null_reg;
  logic        timeout_flag_reg, sleep_flag_reg;
  logic [1:0]  ctrl_reg;
  logic [4:0]  ujl_reg;
  logic [7:0]  pins_s1_reg, pins_s2_reg;
  logic [12:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp_reg;
  logic        rd_en_reg, wr_en_reg, psc_reg, wdt_reg, slp_reg, gie_reg;
  logic [6:0]  rd_addr_reg, wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic [15:0] sw_rdata_reg;

  // field split of the executing word
  fbd_pkg::fbd_group_t grp;
  logic [3:0]  op_sel;
  logic        dbit;
  logic [6:0]  f_idx;
  logic [2:0]  b_pos;
  logic [7:0]  k8;
  logic [10:0] k11;
  logic        run, commit, uses_f;

  assign grp    = fbd_pkg::fbd_group_t'(ir_reg[13:12]);
  assign op_sel = ir_reg[11:8];
  assign dbit   = ir_reg[7];
  assign f_idx  = ir_reg[6:0];
  assign b_pos  = ir_reg[9:7];
  assign k8     = ir_reg[7:0];
  assign k11    = ir_reg[10:0];
  assign run    = ctrl_reg[`FBD_CTRL_RUN];
  assign commit = run && (phase_reg == fbd_pkg::FBD_Q4);

  // register operand needed by every byte op except the d=0 misc/clear
  assign uses_f = ir_valid_reg &&
    ((grp == fbd_pkg::FBD_GRP_BIT) ||
     (grp == fbd_pkg::FBD_GRP_BYTE && (dbit || op_sel[3:1] != 3'b000)));

  // adder giving {nibble carry, carry, sum}
  function automatic logic [9:0] fbd_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin);
    logic [8:0] s;
    logic [4:0] lo;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {lo[4], s[8], s[7:0]};
  endfunction : fbd_add

  logic [7:0] res, bmask;
  logic [9:0] sum;
  logic       c_n, dc_n, c_upd, dc_upd, z_upd;
  logic       wr_acc, wr_f, skip, jump, push, pop, ret_op;
  logic       sleep_op, wdt_op, gie_op;

  // execute stage datapath and decode
  always_comb begin
    res = 8'h00; c_n = carry_reg; dc_n = nibble_carry_reg;
    c_upd = 1'b0; dc_upd = 1'b0; z_upd = 1'b0;
    wr_acc = 1'b0; wr_f = 1'b0; skip = 1'b0; jump = 1'b0;
    push = 1'b0; pop = 1'b0; ret_op = 1'b0;
    sleep_op = 1'b0; wdt_op = 1'b0; gie_op = 1'b0;
    sum = 10'h000;
    bmask = 8'h01 << b_pos;
    if (ir_valid_reg) begin
      case (grp)
        fbd_pkg::FBD_GRP_BYTE: begin
          wr_acc = ~dbit;
          wr_f   = dbit;
          case (op_sel)
            `FBD_SEL_MISC: begin
              wr_acc = 1'b0;
              res    = acc_reg;
              if (!dbit) begin
                // unlisted low bytes run as nop, x bits ignored
                case (ir_reg[7:0])
                  `FBD_W_RETURN: ret_op = 1'b1;
                  `FBD_W_RETFIE: begin
                    ret_op = 1'b1;
                    gie_op = 1'b1;
                  end
                  `FBD_W_STANDBY: sleep_op = 1'b1;
                  `FBD_W_WDTCLR:  wdt_op = 1'b1;
                  default: ;
                endcase
              end
            end
            `FBD_SEL_CLR: begin
              res = 8'h00;
              z_upd = 1'b1;
            end
            `FBD_SEL_ADD, `FBD_SEL_SUB: begin
              sum = (op_sel == `FBD_SEL_ADD) ?
                    fbd_add(opnd_reg, acc_reg, 1'b0) :
                    fbd_add(opnd_reg, ~acc_reg, 1'b1);
              res = sum[7:0];
              c_n = sum[8]; dc_n = sum[9];
              c_upd = 1'b1; dc_upd = 1'b1; z_upd = 1'b1;
            end
            `FBD_SEL_AND: begin res = acc_reg & opnd_reg; z_upd = 1'b1; end
            `FBD_SEL_IOR: begin res = acc_reg | opnd_reg; z_upd = 1'b1; end
            `FBD_SEL_XOR: begin res = acc_reg ^ opnd_reg; z_upd = 1'b1; end
            `FBD_SEL_COM: begin res = ~opnd_reg; z_upd = 1'b1; end
            `FBD_SEL_DEC: begin res = opnd_reg - 8'h01; z_upd = 1'b1; end
            `FBD_SEL_INC: begin res = opnd_reg + 8'h01; z_upd = 1'b1; end
            `FBD_SEL_MOV: begin res = opnd_reg; z_upd = 1'b1; end
            `FBD_SEL_SWAP: res = {opnd_reg[3:0], opnd_reg[7:4]};
            `FBD_SEL_DECSKP, `FBD_SEL_INCSKP: begin
              res = op_sel[2] ? opnd_reg + 8'h01 : opnd_reg - 8'h01;
              skip = (res == 8'h00);
            end
            `FBD_SEL_RL: begin
              res = {opnd_reg[6:0], carry_reg};
              c_n = opnd_reg[7];
              c_upd = 1'b1;
            end
            default: begin
              res = {carry_reg, opnd_reg[7:1]};
              c_n = opnd_reg[0];
              c_upd = 1'b1;
            end
          endcase
        end
        fbd_pkg::FBD_GRP_BIT: begin
          case (op_sel[3:2])
            2'b00: begin res = opnd_reg & ~bmask; wr_f = 1'b1; end
            2'b01: begin res = opnd_reg | bmask; wr_f = 1'b1; end
            2'b10: skip = ((opnd_reg & bmask) == 8'h00);
            default: skip = ((opnd_reg & bmask) != 8'h00);
          endcase
        end
        fbd_pkg::FBD_GRP_CTRL: begin
          jump = 1'b1;
          push = ~ir_reg[11];
        end
        default: begin
          wr_acc = 1'b1;
          case (op_sel[3:2])
            2'b00: res = k8;
            2'b01: begin res = k8; ret_op = 1'b1; end
            2'b10: begin
              z_upd = 1'b1;
              case (op_sel[1:0])
                2'b00: res = acc_reg | k8;
                2'b01: res = acc_reg & k8;
                2'b10: res = acc_reg ^ k8;
                default: begin res = acc_reg; wr_acc = 1'b0;
                  z_upd = 1'b0; end
              endcase
            end
            default: begin
              // lowest selector bit is don't-care
              sum = op_sel[1] ? fbd_add(k8, acc_reg, 1'b0) :
                                fbd_add(k8, ~acc_reg, 1'b1);
              res = sum[7:0];
              c_n = sum[8]; dc_n = sum[9];
              c_upd = 1'b1; dc_upd = 1'b1; z_upd = 1'b1;
            end
          endcase
        end
      endcase
    end
    pop = ret_op;
  end

  // pin levels cross two flops before any use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_s1_reg <= 8'h00;
      pins_s2_reg <= 8'h00;
    end else begin
      pins_s1_reg <= port_pins;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // phase sequencer; stops between periods while run is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) phase_reg <= fbd_pkg::FBD_Q1;
    else if (run) begin
      case (phase_reg)
        fbd_pkg::FBD_Q1: phase_reg <= fbd_pkg::FBD_Q2;
        fbd_pkg::FBD_Q2: phase_reg <= fbd_pkg::FBD_Q3;
        fbd_pkg::FBD_Q3: phase_reg <= fbd_pkg::FBD_Q4;
        default:         phase_reg <= fbd_pkg::FBD_Q1;
      endcase
    end
  end

  // read request in Q2, even for write-only ops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_en_reg   <= 1'b0;
      rd_addr_reg <= 7'h00;
    end else begin
      rd_en_reg <= run && phase_reg == fbd_pkg::FBD_Q1 && uses_f;
      if (run && phase_reg == fbd_pkg::FBD_Q1 && uses_f)
        rd_addr_reg <= f_idx;
    end
  end

  // operand is captured at the end of Q3; the port yields its pins, not the latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) opnd_reg <= 8'h00;
    else if (run && phase_reg == fbd_pkg::FBD_Q3)
      opnd_reg <= (rd_addr_reg == `FBD_PORT_ADDR) ?
                  pins_s2_reg : rf_rd_data;
  end

  // accumulator and flags commit at the end of Q4
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg          <= 8'h00;
      carry_reg        <= 1'b0;
      nibble_carry_reg <= 1'b0;
      result_null_reg  <= 1'b0;
      timeout_flag_reg <= 1'b1;
      sleep_flag_reg   <= 1'b1;
    end else if (commit) begin
      if (wr_acc) acc_reg <= res;
      if (c_upd)  carry_reg <= c_n;
      if (dc_upd) nibble_carry_reg <= dc_n;
      if (z_upd)  result_null_reg <= (res == 8'h00);
      if (sleep_op || wdt_op) begin
        timeout_flag_reg <= 1'b1;
        sleep_flag_reg   <= wdt_op;
      end
    end
  end

  // write-back strobes, one cycle in the following Q1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
      psc_reg     <= 1'b0;
    end else begin
      wr_en_reg <= commit && wr_f;
      psc_reg   <= commit && wr_f && f_idx == `FBD_TIMER_ADDR &&
                   ctrl_reg[`FBD_CTRL_PSA];
      if (commit && wr_f) begin
        wr_addr_reg <= f_idx;
        wr_data_reg <= res;
      end
    end
  end

  // side-effect pulses toward watchdog, power and interrupt logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_reg <= 1'b0;
      slp_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else begin
      wdt_reg <= commit && (sleep_op || wdt_op);
      slp_reg <= commit && sleep_op;
      gie_reg <= commit && gie_op;
    end
  end

  // fetch pipeline; a taken skip or branch flushes the fetched word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fp_reg       <= `FBD_FP_RESET;
      ir_reg       <= 14'h0000;
      ir_valid_reg <= 1'b0;
      sp_reg       <= '0;
    end else if (commit) begin
      ir_reg       <= instr_word;
      ir_valid_reg <= ~(skip || jump || pop);
      if (jump) fp_reg <= {ujl_reg[4:3], k11};
      else if (pop) fp_reg <= stack_mem[sp_reg - 1'b1];
      else fp_reg <= fp_reg + 13'h0001;
      if (push) sp_reg <= sp_reg + 1'b1;
      else if (pop) sp_reg <= sp_reg - 1'b1;
    end
  end

  // circular stack; overflow silently wraps like the real part
  always_ff @(posedge clk) begin
    if (commit && push) stack_mem[sp_reg] <= fp_reg;
  end

  // software port: writes steer run and jump latch, reads show state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= `FBD_CTRL_RESET;
      ujl_reg      <= `FBD_UJL_RESET;
      sw_rdata_reg <= 16'h0000;
    end else begin
      if (sw_wr && sw_addr == `FBD_ADDR_CTRL) ctrl_reg <= sw_wdata[1:0];
      if (sw_wr && sw_addr == `FBD_ADDR_UJL)  ujl_reg <= sw_wdata[4:0];
      sw_rdata_reg <= 16'h0000;
      if (sw_rd) begin
        case (sw_addr)
          `FBD_ADDR_CTRL:   sw_rdata_reg <= {14'h0000, ctrl_reg};
          `FBD_ADDR_STATUS: sw_rdata_reg <= {11'h000, timeout_flag_reg,
            sleep_flag_reg, result_null_reg, nibble_carry_reg, carry_reg};
          `FBD_ADDR_ACC:    sw_rdata_reg <= {8'h00, acc_reg};
          `FBD_ADDR_FPTR:   sw_rdata_reg <= {3'h0, fp_reg};
          `FBD_ADDR_UJL:    sw_rdata_reg <= {11'h000, ujl_reg};
          default:          sw_rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign fetch_pointer = fp_reg;
  assign rf_rd_en      = rd_en_reg;
  assign rf_rd_addr    = rd_addr_reg;
  assign rf_wr_en      = wr_en_reg;
  assign rf_wr_addr    = wr_addr_reg;
  assign rf_wr_data    = wr_data_reg;
  assign prescaler_clr = psc_reg;
  assign wdt_clr       = wdt_reg;
  assign sleep_req     = slp_reg;
  assign gie_set       = gie_reg;
  assign sw_rdata      = sw_rdata_reg;

  // checks
  AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (!nrst)
    (phase_reg == fbd_pkg::FBD_Q1 && run) ##1 run ##1 run ##1 run
    |=> phase_reg == fbd_pkg::FBD_Q1)
    else $error("phase did not wrap after four periods");

  AST_READ_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    rf_wr_en |-> $past(rf_rd_en, 3) && $past(rf_rd_addr, 3) == rf_wr_addr)
    else $error("register written without prior read");

  AST_ADD_TO_REG: assert property (@(posedge clk) disable iff (!nrst)
    (commit && ir_valid_reg && grp == fbd_pkg::FBD_GRP_BYTE &&
     op_sel == `FBD_SEL_ADD && dbit)
    |=> rf_wr_en && rf_wr_data == $past(acc_reg + opnd_reg)
        && acc_reg == $past(acc_reg))
    else $error("add with d=1 did not write register");

  AST_SKIP_FLUSH: assert property (@(posedge clk) disable iff (!nrst)
    (commit && (skip || jump)) |=> !ir_valid_reg [*4])
    else $error("skipped cycle not a nop");

  AST_PSC_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    prescaler_clr |-> rf_wr_en && rf_wr_addr == `FBD_TIMER_ADDR
                      && ctrl_reg[`FBD_CTRL_PSA])
    else $error("prescaler clear without timer write");

  AST_JUMP_TARGET: assert property (@(posedge clk) disable iff (!nrst)
    (commit && jump) |=> fetch_pointer == {$past(ujl_reg[4:3]), $past(k11)})
    else $error("jump target wrong");

  AST_SWAP_NOFLAG: assert property (@(posedge clk) disable iff (!nrst)
    (commit && ir_valid_reg && grp == fbd_pkg::FBD_GRP_BYTE &&
     op_sel == `FBD_SEL_SWAP)
    |=> $stable(carry_reg) && $stable(nibble_carry_reg)
        && $stable(result_null_reg))
    else $error("swap changed a flag");

  AST_STANDBY: assert property (@(posedge clk) disable iff (!nrst)
    (commit && sleep_op) |=> !sleep_flag_reg && timeout_flag_reg
                             && sleep_req && wdt_clr)
    else $error("standby flags wrong");

  AST_CLEAR_REG: assert property (@(posedge clk) disable iff (!nrst)
    (commit && ir_valid_reg && grp == fbd_pkg::FBD_GRP_BYTE &&
     op_sel == `FBD_SEL_CLR && dbit)
    |=> rf_wr_en && rf_wr_data == 8'h00 && result_null_reg)
    else $error("clear register failed");

  AST_RET_LIT: assert property (@(posedge clk) disable iff (!nrst)
    (commit && grp == fbd_pkg::FBD_GRP_LIT && ir_valid_reg &&
     op_sel[3:2] == 2'b01) |=> acc_reg == $past(k8) && !ir_valid_reg)
    else $error("return with literal wrong");

endmodule : fbd_decoder

//--- test/fbd_mem_model.sv
`timescale 1ns/1ns
// program store and register file on the far side of the decoder
module fbd_mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [12:0] fetch_pointer,
  input  wire logic        rf_rd_en,
  input  wire logic [6:0]  rf_rd_addr,
  input  wire logic        rf_wr_en,
  input  wire logic [6:0]  rf_wr_addr,
  input  wire logic [7:0]  rf_wr_data,
  output logic      [13:0] instr_word,
  output logic      [7:0]  rf_rd_data
);
  logic [13:0] prog [0:8191];
  logic [7:0]  rf   [0:127];
  // whole word at the fetch address, no partial fetch
  assign instr_word = prog[fetch_pointer];
  // answer one cycle after the request, scrambled otherwise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_rd_data <= 8'h00;
    end else if (rf_rd_en) begin
      rf_rd_data <= rf[rf_rd_addr];
    end else begin
      rf_rd_data <= ~rf_rd_data; // stale data must not look valid
    end
  end
  // writes land on the strobe edge
  always @(posedge clk) begin
    if (rf_wr_en) begin
      rf[rf_wr_addr] <= rf_wr_data;
    end
  end
endmodule : fbd_mem_model

//--- test/tb_top.sv
`timescale 1ns/1ns
`include "fbd_defines.svh"
module tb_top;
  logic        clk, nrst, sw_wr, sw_rd;
  logic        rf_rd_en, rf_wr_en, prescaler_clr, wdt_clr, sleep_req;
  logic        gie_set;
  logic [13:0] instr_word;
  logic [12:0] fetch_pointer;
  logic [6:0]  rf_rd_addr, rf_wr_addr;
  logic [7:0]  rf_rd_data, rf_wr_data, port_pins, sw_addr;
  logic [15:0] sw_wdata, sw_rdata, rd_val;
  logic [13:0] prog_q [$];
  logic [29:0] tbl [0:22];
  int          num_errors, checks_done, n_psc, n_wdt, n_slp, n_rd, n_tmr;
  int          n_gie;

  fbd_decoder u_fbd_decoder (.clk, .nrst, .instr_word, .fetch_pointer,
    .rf_rd_en, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr,
    .rf_wr_data, .port_pins, .prescaler_clr, .wdt_clr, .sleep_req,
    .gie_set, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  fbd_mem_model u_fbd_mem_model (.clk, .nrst, .fetch_pointer, .rf_rd_en,
    .rf_rd_addr, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .instr_word,
    .rf_rd_data);

  always #4 clk = ~clk;

  // pulse and read counters, cleared per run
  always @(posedge clk) begin
    if (nrst) begin
      n_psc += int'(prescaler_clr);
      n_wdt += int'(wdt_clr);
      n_slp += int'(sleep_req);
      n_rd  += int'(rf_rd_en);
      n_tmr += int'(rf_rd_en && rf_rd_addr == `FBD_TIMER_ADDR);
      n_gie += int'(gie_set);
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  // read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [7:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    rd_val = sw_rdata;
  endtask : sw_read

  // unused words are nops so a runaway fetch stays harmless
  task automatic load_prog;
    for (int i = 0; i < 8192; i++) u_fbd_mem_model.prog[i] = 14'h0000;
    foreach (prog_q[j]) u_fbd_mem_model.prog[j] = prog_q[j];
  endtask : load_prog

  // reset, start the core, wait for the parking loop, then halt
  task automatic go(input logic [12:0] fin, input logic [15:0] ctrl, ujl);
    int i;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    {n_psc, n_wdt, n_slp, n_rd, n_tmr, n_gie} = '0;
    sw_write(`FBD_ADDR_UJL, ujl);
    sw_write(`FBD_ADDR_CTRL, ctrl);
    for (i = 0; i < 3000 && fetch_pointer !== fin; i++) @(posedge clk);
    if (fetch_pointer !== fin) begin
      num_errors++;
      close_out();
    end
    repeat (12) @(posedge clk);
    sw_write(`FBD_ADDR_CTRL, 16'h0000);
  endtask : go

  task automatic s_regs;
    prog_q = '{14'h2800};
    load_prog();
    go(13'h0000, 16'h0000, 16'hffff);
    sw_read(`FBD_ADDR_STATUS);
    chk("status", rd_val, 16'h0018);
    sw_read(8'h40);
    chk("unmapped", rd_val, 16'h0000);
    sw_read(`FBD_ADDR_UJL);
    chk("ujl", rd_val, 16'h001f);
    // prescaler assignment alone must not start the core
    sw_write(`FBD_ADDR_CTRL, 16'h0002);
    sw_read(`FBD_ADDR_CTRL);
    chk("ctrl", rd_val, 16'h0002);
  endtask : s_regs

  // W=0x0f, f(0x10)=0x3c, then one operation into W
  task automatic s_ops;
    for (int k = 0; k < 23; k++) begin
      prog_q = '{14'h303c, 14'h0090, 14'h300f, tbl[k][29:16], 14'h2804};
      load_prog();
      go(13'h0004, 16'h0001, 16'h0000);
      sw_read(`FBD_ADDR_ACC);
      chk("acc", rd_val, {8'h00, tbl[k][7:0]});
      sw_read(`FBD_ADDR_STATUS);
      chk("flags", rd_val, {8'h00, tbl[k][15:8]});
      chk("reg", u_fbd_mem_model.rf[16], 16'h003c);
    end
  endtask : s_ops

  task automatic s_result_to_reg;
    prog_q = '{14'h303c, 14'h0090, 14'h0790, 14'h0e10, 14'h2804};
    load_prog();
    go(13'h0004, 16'h0001, 16'h0000);
    chk("reg", u_fbd_mem_model.rf[16], 16'h0078);
    sw_read(`FBD_ADDR_ACC);
    chk("acc", rd_val, 16'h0087);
    sw_read(`FBD_ADDR_STATUS);
    chk("flags", rd_val, 16'h001a);
  endtask : s_result_to_reg

  // skipped slots hold register writes that must never happen
  task automatic s_skip;
    prog_q = '{14'h3001, 14'h00a0, 14'h0ba0, 14'h0aa0, 14'h17a0, 14'h1fa0,
               14'h0aa0, 14'h1b20, 14'h0aa0, 14'h3044, 14'h280a};
    load_prog();
    go(13'h000a, 16'h0001, 16'h0000);
    chk("reg", u_fbd_mem_model.rf[32], 16'h0080);
    chk("reads", 16'(n_rd), 16'h0005);
    sw_read(`FBD_ADDR_ACC);
    chk("acc", rd_val, 16'h0044);
    sw_read(`FBD_ADDR_STATUS);
    chk("flags", rd_val, 16'h0018);
  endtask : s_skip

  task automatic s_port_timer;
    for (int p = 0; p < 2; p++) begin
      prog_q = '{14'h0885, 14'h0181, 14'h2802};
      load_prog();
      u_fbd_mem_model.rf[1] = 8'h77;
      go(13'h0002, 16'(1 + 2 * p), 16'h0000);
      chk("port", u_fbd_mem_model.rf[5], 16'h00a5);
      chk("timer", u_fbd_mem_model.rf[1], 16'h0000);
      chk("tmr_rd", 16'(n_tmr), 16'h0001);
      chk("psc", 16'(n_psc), 16'(p));
      sw_read(`FBD_ADDR_STATUS);
      chk("flags", rd_val, 16'h001c);
    end
  endtask : s_port_timer

  // nested call through the upper latch, returns, standby, wdt clear,
  // then a second call left by the interrupt return
  task automatic s_call;
    prog_q = '{14'h2010, 14'h0063, 14'h0064, 14'h2018, 14'h2804};
    load_prog();
    u_fbd_mem_model.prog[13'h0804] = 14'h2804;
    u_fbd_mem_model.prog[13'h0818] = 14'h0009;
    u_fbd_mem_model.prog[13'h0810] = 14'h2020;
    u_fbd_mem_model.prog[13'h0811] = 14'h0008;
    u_fbd_mem_model.prog[13'h0820] = 14'h345a;
    go(13'h0804, 16'h0001, 16'h0008);
    chk("gie", 16'(n_gie), 16'h0001);
    sw_read(`FBD_ADDR_ACC);
    chk("acc", rd_val, 16'h005a);
    chk("sleep", 16'(n_slp), 16'h0001);
    chk("wdt", 16'(n_wdt), 16'h0002);
    sw_read(`FBD_ADDR_STATUS);
    chk("flags", rd_val, 16'h0018);
  endtask : s_call

  initial begin
    {clk, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
    {num_errors, checks_done} = '0;
    port_pins = 8'ha5;
    nrst = 1'b0;
    tbl = '{{14'h0710, 16'h1a4b}, {14'h0210, 16'h192d},
      {14'h0510, 16'h180c}, {14'h0410, 16'h183f}, {14'h0610, 16'h1833},
      {14'h0910, 16'h18c3}, {14'h0310, 16'h183b}, {14'h0a10, 16'h183d},
      {14'h0810, 16'h183c}, {14'h0e10, 16'h18c3}, {14'h0c10, 16'h181e},
      {14'h0d10, 16'h1878}, {14'h0b10, 16'h183b}, {14'h0f10, 16'h183d},
      {14'h3830, 16'h183f}, {14'h39f0, 16'h1c00}, {14'h3a0f, 16'h1c00},
      {14'h3c0e, 16'h18ff}, {14'h3d1f, 16'h1b10}, {14'h3ef1, 16'h1f00},
      {14'h3f01, 16'h1a10}, {14'h3322, 16'h1822}, {14'h017f, 16'h1c00}};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    s_ops();
    s_result_to_reg();
    s_skip();
    s_port_timer();
    s_call();
    close_out();
  end
endmodule : tb_top
